// ### design/bbps_pkg.sv
package bbps_pkg;
  // Register offsets
  localparam logic [7:0] SWITCHING_CONFIG_ADDR    = 8'h01;
  localparam logic [7:0] PEAK_CURRENT_LIMITS_ADDR = 8'h03;
  localparam logic [7:0] PHASE_STATUS_ADDR        = 8'h0A;
  // Field positions in switching_config
  localparam int OUT_ENABLE_BIT  = 0;
  localparam int MODE_BIT        = 2;
  localparam int ZC_CMP_OFF_BIT  = 4;
  // Field positions in peak_current_limits
  localparam int PRIMARY_LSB     = 0;
  localparam int SECONDARY_LSB   = 4;
  localparam int LIMIT_W         = 4;
  // Reset values
  localparam logic [7:0] SWITCHING_CONFIG_RST    = 8'h00;
  localparam logic [7:0] PEAK_CURRENT_LIMITS_RST = 8'h00;
  localparam logic [3:0] SOFTSTART_PRIMARY_PEAK   = 4'h2;
  localparam logic [3:0] SOFTSTART_SECONDARY_PEAK = 4'h1;
  // Timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int CHARGE_TIMEOUT_NS = 500;
  localparam int FREEWHEEL_MIN_NS  = 30;
  localparam logic [3:0] CHARGE_TIMEOUT_CYC =
    4'((CHARGE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] FREEWHEEL_CYC_RAW =
    4'(FREEWHEEL_MIN_NS / CLK_PERIOD_NS);
  localparam logic [3:0] FREEWHEEL_CYC =
    (FREEWHEEL_CYC_RAW == 4'h0) ? 4'h1 : FREEWHEEL_CYC_RAW;
  // Phase states
  typedef enum logic [2:0] {
    BBPS_OFF, BBPS_DEAD, BBPS_P1, BBPS_P2, BBPS_P3, BBPS_P4
  } bbps_phase_t;
endpackage

// ### design/bbps_sequencer.sv
`timescale 1ns/1ps
module bbps_sequencer
  import bbps_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       charge_req,
  input  wire logic       vin_gt_vout,
  input  wire logic       peak1_hit,
  input  wire logic       peak12_hit,
  input  wire logic       valley_hit,
  input  wire logic       zero_cross,
  input  wire logic       softstart_done,
  output logic            input_side_pmos,
  output logic            output_side_pmos,
  output logic            input_side_nmos,
  output logic            output_side_nmos,
  output logic      [3:0] primary_peak_limit,
  output logic      [3:0] secondary_peak_increment,
  output logic            valley_force_zero,
  output logic            irq_out_n_o,
  output logic            irq_out_n_oe_n
);
  parameter logic DEFAULT_ON = 1'b1;

  typedef struct packed {
    bbps_phase_t phase;
    bbps_phase_t next;
    logic [3:0]  tmr;
    logic [7:0]  cfg;
    logic [7:0]  lim;
    logic [7:0]  rdata;
    logic        started;
    logic        ss_done;
    logic        irq_pend;
    logic        sw_ip;
    logic        sw_op;
    logic        sw_in;
    logic        sw_on;
    logic [3:0]  pk1;
    logic [3:0]  pk2;
    logic        vz;
    logic        irq_oe_n;
  } bbps_state_t;

  bbps_state_t s_q;
  bbps_state_t s_d;
  logic        buck_only;
  logic        zc_off;
  logic        enabled;
  logic        ccm;
  bbps_phase_t charge_phase;
  logic        timeout;

  assign buck_only    = s_q.cfg[MODE_BIT];
  assign zc_off       = s_q.cfg[ZC_CMP_OFF_BIT];
  assign enabled      = s_q.cfg[OUT_ENABLE_BIT];
  assign ccm          = s_q.ss_done;
  assign charge_phase = buck_only ? BBPS_P1 : BBPS_P2;
  // Expiry after the counted cycles of phase 1, entry cycle included
  assign timeout      = (s_q.tmr >= (CHARGE_TIMEOUT_CYC - 4'h1));

  // Next-state logic
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    // Register writes
    if (reg_wr) begin
      if (reg_addr == SWITCHING_CONFIG_ADDR) begin
        s_d.cfg = reg_wdata;
      end else if (reg_addr == PEAK_CURRENT_LIMITS_ADDR) begin
        s_d.lim = reg_wdata;
      end
    end
    // Register reads; status read clears the pending event
    if (reg_rd) begin
      case (reg_addr)
        SWITCHING_CONFIG_ADDR:    s_d.rdata = s_q.cfg;
        PEAK_CURRENT_LIMITS_ADDR: s_d.rdata = s_q.lim;
        PHASE_STATUS_ADDR: begin
          s_d.rdata    = {s_q.irq_pend, s_q.ss_done, 3'h0, 3'(s_q.phase)};
          s_d.irq_pend = 1'b0;
        end
        default:                  s_d.rdata = 8'h00;
      endcase
    end
    // Start-up completion event; set wins over clear
    s_d.ss_done = s_q.ss_done | (s_q.started & softstart_done);
    if (s_q.started && softstart_done && !s_q.ss_done) begin
      s_d.irq_pend = 1'b1;
    end
    // Timeout counter, restarted on entry to phase 1
    if (s_q.phase == BBPS_P1) begin
      if (!timeout) begin
        s_d.tmr = s_q.tmr + 4'h1;
      end
    end else begin
      s_d.tmr = 4'h0;
    end
    // Phase sequencing
    case (s_q.phase)
      BBPS_OFF: begin
        if (enabled) begin
          s_d.started = 1'b1;
          s_d.next    = BBPS_P4;
          s_d.phase   = BBPS_DEAD;
        end
      end
      BBPS_DEAD: begin
        s_d.phase = s_q.next;
      end
      BBPS_P2: begin
        if (peak1_hit) begin
          s_d.next  = BBPS_P1;
          s_d.phase = BBPS_DEAD;
        end
      end
      BBPS_P1: begin
        if (buck_only) begin
          if (peak1_hit || timeout) begin
            s_d.next  = BBPS_P3;
            s_d.phase = BBPS_DEAD;
          end
        end else if (vin_gt_vout) begin
          if (peak12_hit || timeout) begin
            s_d.next  = BBPS_P3;
            s_d.phase = BBPS_DEAD;
          end
        end else if (valley_hit || timeout) begin
          s_d.next  = BBPS_P3;
          s_d.phase = BBPS_DEAD;
        end
      end
      BBPS_P3: begin
        if (zero_cross || (valley_hit && (!ccm || zc_off))) begin
          s_d.next  = BBPS_P4;
          s_d.phase = BBPS_DEAD;
        end else if (valley_hit) begin
          s_d.next  = charge_phase;
          s_d.phase = BBPS_DEAD;
        end else begin
          s_d.phase = BBPS_P3;
        end
      end
      BBPS_P4: begin
        // Freewheel at least one cycle, then wait for charge demand
        if (charge_req && FREEWHEEL_CYC != 4'h0) begin
          s_d.next  = charge_phase;
          s_d.phase = BBPS_DEAD;
        end
      end
      default: begin
        s_d.phase = BBPS_OFF;
      end
    endcase
    // Disable drops back to all-off
    if (!enabled) begin
      s_d.phase = BBPS_OFF;
      s_d.next  = BBPS_OFF;
    end
    // Switch pairs per phase
    s_d.sw_ip = (s_d.phase == BBPS_P1) || (s_d.phase == BBPS_P2);
    s_d.sw_op = (s_d.phase == BBPS_P1) || (s_d.phase == BBPS_P3);
    s_d.sw_in = (s_d.phase == BBPS_P3) || (s_d.phase == BBPS_P4);
    s_d.sw_on = (s_d.phase == BBPS_P2) || (s_d.phase == BBPS_P4);
    // Limits to the comparators: soft-start overrides until done
    if (s_d.ss_done) begin
      s_d.pk1 = s_d.lim[PRIMARY_LSB +: LIMIT_W];
      s_d.pk2 = s_d.lim[SECONDARY_LSB +: LIMIT_W];
      s_d.vz  = 1'b0;
    end else begin
      s_d.pk1 = SOFTSTART_PRIMARY_PEAK;
      s_d.pk2 = SOFTSTART_SECONDARY_PEAK;
      s_d.vz  = 1'b1;
    end
    s_d.irq_oe_n = ~s_d.irq_pend;
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.phase    <= BBPS_OFF;
      s_q.next     <= BBPS_OFF;
      s_q.cfg      <= SWITCHING_CONFIG_RST | {7'h00, DEFAULT_ON};
      s_q.lim      <= PEAK_CURRENT_LIMITS_RST;
      s_q.pk1      <= SOFTSTART_PRIMARY_PEAK;
      s_q.pk2      <= SOFTSTART_SECONDARY_PEAK;
      s_q.vz       <= 1'b1;
      s_q.irq_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops, except irq_out_n_o which is tied low
  assign reg_rdata                = s_q.rdata;
  assign input_side_pmos          = s_q.sw_ip;
  assign output_side_pmos         = s_q.sw_op;
  assign input_side_nmos          = s_q.sw_in;
  assign output_side_nmos         = s_q.sw_on;
  assign primary_peak_limit       = s_q.pk1;
  assign secondary_peak_increment = s_q.pk2;
  assign valley_force_zero        = s_q.vz;
  assign irq_out_n_o              = 1'b0; // Open drain only pulls low
  assign irq_out_n_oe_n           = s_q.irq_oe_n;
endmodule

// ### tb/bbps_sequencer_asserts.sv
`timescale 1ns/1ps
module bbps_chk
  import bbps_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       charge_req,
  input wire logic       vin_gt_vout,
  input wire logic       peak1_hit,
  input wire logic       peak12_hit,
  input wire logic       zero_cross,
  input wire logic       input_side_pmos,
  input wire logic       output_side_pmos,
  input wire logic       input_side_nmos,
  input wire logic       output_side_nmos,
  input wire logic [3:0] primary_peak_limit,
  input wire logic [3:0] secondary_peak_increment,
  input wire logic       valley_force_zero,
  input wire logic       irq_out_n_o,
  input wire logic       irq_out_n_oe_n
);
  logic [3:0] sw;
  logic [3:0] p1_q;
  logic       wr_q;
  logic       calm;
  // Switch pair as one code; no register write in this or the last cycle
  assign sw   = {input_side_pmos, output_side_pmos, input_side_nmos, output_side_nmos};
  assign calm = !reg_wr && !wr_q;
  // Run length of phase 1 and last write
  always_ff @(posedge clk) begin
    wr_q <= reg_wr;
    p1_q <= (rstn && sw == 4'hC) ? p1_q + 4'h1 : 4'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_legal_pair: assert property (sw inside {4'h0, 4'hC, 4'h9, 4'h6, 4'h3})
    else $error("illegal switch pair");
  chk_dead_gap: assert property (sw != 4'h0 && $past(sw) != 4'h0 |-> sw == $past(sw))
    else $error("pair changed without dead cycle");
  chk_p2_exit: assert property (sw == 4'h9 && peak1_hit && calm |=> sw == 4'h0 ##1 sw == 4'hC)
    else $error("phase 2 did not move to phase 1");
  chk_charge_timeout: assert property (p1_q <= 4'h5)
    else $error("phase 1 outlived its timeout");
  chk_p1_peak: assert property (sw == 4'hC && vin_gt_vout && peak12_hit && calm |=> sw == 4'h0)
    else $error("phase 1 ignored summed peak");
  chk_p3_zero: assert property (sw == 4'h6 && zero_cross && calm |=> sw == 4'h0 ##1 sw == 4'h3)
    else $error("zero crossing did not freewheel");
  chk_p4_wait: assert property (sw == 4'h3 && !charge_req && calm |=> sw == 4'h3)
    else $error("freewheel left without request");
  chk_irq_drive: assert property (irq_out_n_o == 1'b0)
    else $error("interrupt pin drives high");
  chk_ss_limits: assert property (valley_force_zero |-> primary_peak_limit == SOFTSTART_PRIMARY_PEAK
    && secondary_peak_increment == SOFTSTART_SECONDARY_PEAK)
    else $error("soft-start limits not applied");
  cover property (sw == 4'h9 ##2 sw == 4'hC);
  cover property (sw == 4'h6 ##2 sw == 4'h3);
  cover property ($fell(irq_out_n_oe_n));
endmodule
bind bbps_sequencer bbps_chk bbps_chk_inst (.*);

// ### tb/bbps_stage.sv
`timescale 1ns/1ps
module bbps_stage #(
  parameter int VALLEY = 2
) (
  input wire logic       clk,
  input wire logic [3:0] sw,
  input wire logic       vin_gt_vout,
  input wire logic [3:0] primary_peak_limit,
  input wire logic [3:0] secondary_peak_increment,
  input wire logic       valley_force_zero,
  output logic           peak1_hit,
  output logic           peak12_hit,
  output logic           valley_hit,
  output logic           zero_cross
);
  int cur = 0;
  // Current rises while charging, falls while discharging, never below zero
  always @(posedge clk) begin
    if (sw == 4'h9 || (sw == 4'hC && vin_gt_vout)) cur <= cur + 1;
    else if ((sw == 4'h6 || sw == 4'hC) && cur > 0) cur <= cur - 1;
  end
  // Comparator levels
  assign peak1_hit  = cur >= int'(primary_peak_limit);
  assign peak12_hit = cur >= int'(primary_peak_limit) + int'(secondary_peak_increment);
  assign valley_hit = cur <= (valley_force_zero ? 0 : VALLEY);
  assign zero_cross = cur <= 0;
endmodule

// ### tb/tb_bbps_sequencer.sv
`timescale 1ns/1ps
module tb_bbps_sequencer;
  import bbps_pkg::*;
  logic        clk, rstn, reg_wr, reg_rd, charge_req, vin_gt_vout, softstart_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_v;
  logic        peak1_hit, peak12_hit, valley_hit, zero_cross, valley_force_zero;
  logic        input_side_pmos, output_side_pmos, input_side_nmos, output_side_nmos;
  logic        irq_out_n_o, irq_out_n_oe_n;
  logic [3:0]  primary_peak_limit, secondary_peak_increment, after_p3;
  logic [15:0] hist;
  int          fails, n_checks, p1_cyc;
  wire  [3:0]  sw = {input_side_pmos, output_side_pmos, input_side_nmos, output_side_nmos};
  bbps_sequencer bbps_sequencer_inst (.*);
  bbps_stage bbps_stage_inst (.*);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask
  // One-cycle charge request, then let the cycle finish
  task automatic pulse;
    @(negedge clk);
    charge_req = 1'b1;
    @(negedge clk);
    charge_req = 1'b0;
    repeat (30) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test;
  end
  // Log each new switch pair and phase 1 length
  always @(negedge clk) begin
    if (sw == 4'hC) p1_cyc++;
    if (sw != 4'h0 && sw != hist[3:0]) begin
      if (hist[3:0] == 4'h6) after_p3 = sw;
      hist = {hist[11:0], sw};
    end
  end
  initial begin
    {rstn, reg_wr, reg_rd, charge_req, softstart_done, reg_addr, reg_wdata} = '0;
    {hist, fails, n_checks, p1_cyc, vin_gt_vout} = {16'h0, 32'h0, 32'h0, 32'h0, 1'b1};
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    wr(8'h02, 8'hFF);
    rd(8'h01);
    check("cfg", rd_v, 8'h01);
    rd(8'h03);
    check("limits reg", rd_v, 8'h00);
    rd(8'h02);
    check("unmapped", rd_v, 8'h00);
    pulse;
    check("bb seq", hist, 16'h9C63);
    wr(8'h01, 8'h05);
    pulse;
    check("buck seq", hist, 16'h3C63);
    vin_gt_vout = 1'b0;
    p1_cyc = 0;
    pulse;
    check("timeout", 16'(p1_cyc), 16'h0005);
    vin_gt_vout = 1'b1;
    wr(8'h01, 8'h01);
    wr(8'h03, 8'h34);
    rd(8'h03);
    check("limits rw", rd_v, 8'h34);
    softstart_done = 1'b1;
    repeat (4) @(negedge clk);
    check("irq low", irq_out_n_oe_n, 1'b0);
    check("limits", {primary_peak_limit, secondary_peak_increment, valley_force_zero}, 9'h086);
    rd(8'h0A);
    check("status", rd_v, 8'hC5);
    repeat (2) @(negedge clk);
    check("irq clear", {irq_out_n_oe_n, irq_out_n_o}, 2'b10);
    charge_req = 1'b1;
    repeat (40) @(negedge clk);
    check("ccm skip", after_p3, 4'h9);
    charge_req = 1'b0;
    wr(8'h01, 8'h11);
    repeat (40) @(negedge clk);
    check("ccm fw", after_p3, 4'h3);
    wr(8'h01, 8'h00);
    repeat (3) @(negedge clk);
    check("off", sw, 4'h0);
    wr(8'h01, 8'h01);
    repeat (4) @(negedge clk);
    check("on", sw, 4'h3);
    stop_test;
  end
endmodule
